// ---- ccc_counter.sv ----
// Continuous up/down counter channel with APB registers
`timescale 1ns/100ps
`default_nettype none
`include "ccc_map.svh"

module ccc_counter (
    input wire logic clock,
    input wire logic rst_n,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic pready,
    output logic [31:0] prdata,
    output logic pslverr,
    input wire logic trk_a,
    input wire logic trk_b,
    input wire logic hw_gate,
    input wire logic latch_in,
    output logic cmp_out,
    output logic irq
);
    import ccc_pkg::*;

    logic [`CCC_CTRL_W-1:0] ctrl_ff;
    logic [`CCC_CFG_W-1:0] cfg_ff;
    logic signed [31:0] cmp_ff, load_ff, hi_ff, lo_ff, count_ff, latch_ff;
    logic [31:0] period_ff, per_cnt_ff;
    logic [`CCC_I_W-1:0] istat_ff, imask_ff, ev_set, ev_clr;
    logic [31:0] prdata_ff, rd_data;
    logic err_ff, rd_err, irq_ff;
    logic acc, wr_acc;
    ccc_eval_t eval_mode;
    ccc_omode_t omode;
    ccc_freq_t cfreq, lfreq;
    logic f1k;

    assign eval_mode = ccc_eval_t'(ctrl_ff[`CCC_C_EVAL]);
    assign omode = ccc_omode_t'(ctrl_ff[`CCC_C_OMODE]);
    assign cfreq = ccc_freq_t'(ctrl_ff[`CCC_C_CFREQ]);
    assign lfreq = ccc_freq_t'(ctrl_ff[`CCC_C_LFREQ]);
    assign f1k = (cfreq == CCC_F_1K);

    // Microsecond tick shared by filters, pulse timer and period base
    logic [6:0] us_cnt_ff;
    logic us_tick;
    assign us_tick = (us_cnt_ff == 7'(`CCC_US_CYC - 1));
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            us_cnt_ff <= 7'h00;
        end else if (us_tick) begin
            us_cnt_ff <= 7'h00;
        end else begin
            us_cnt_ff <= us_cnt_ff + 7'h01;
        end
    end

    // 125 ns is not a whole number of cycles: ticks alternate 12 and 13 cycles
    logic [4:0] tb_cnt_ff;
    logic tb_wrap, tb_tick;
    assign tb_wrap = (tb_cnt_ff == 5'(`CCC_TB_PAIR_CYC - 1));
    assign tb_tick = tb_wrap || (tb_cnt_ff == 5'(`CCC_TB_HALF_CYC - 1));
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            tb_cnt_ff <= 5'h00;
        end else if (tb_wrap) begin
            tb_cnt_ff <= 5'h00;
        end else begin
            tb_cnt_ff <= tb_cnt_ff + 5'h01;
        end
    end

    // Minimum stable time is half a period of the selected maximum frequency
    function automatic logic [9:0] flt_lim(input ccc_freq_t f);
        case (f)
            CCC_F_1K: flt_lim = `CCC_FLT_1K_US;
            CCC_F_2K: flt_lim = `CCC_FLT_2K_US;
            CCC_F_5K: flt_lim = `CCC_FLT_5K_US;
            CCC_F_10K: flt_lim = `CCC_FLT_10K_US;
            CCC_F_30K: flt_lim = `CCC_FLT_30K_US;
            default: flt_lim = `CCC_FLT_60K_US;
        endcase
    endfunction : flt_lim

    logic [3:0] raw, flt, prv_ff;
    logic [9:0] lim_cnt, lim_lat;
    assign raw = {latch_in, hw_gate, trk_b, trk_a};
    assign lim_cnt = flt_lim(cfreq);
    assign lim_lat = flt_lim(lfreq);

    genvar gi;
    generate
        for (gi = 0; gi < 4; gi++) begin : g_flt
            logic [9:0] st_ff;
            logic q_ff;
            logic [9:0] lim;
            assign lim = (gi == 3) ? lim_lat : lim_cnt;
            assign flt[gi] = q_ff;
            always_ff @(posedge clock or negedge rst_n) begin
                if (!rst_n) begin
                    st_ff <= 10'h000;
                    q_ff <= 1'b0;
                end else if (raw[gi] == q_ff) begin
                    st_ff <= 10'h000;
                end else if (us_tick) begin
                    if (st_ff + 10'h001 >= lim) begin
                        q_ff <= raw[gi];
                        st_ff <= 10'h000;
                    end else begin
                        st_ff <= st_ff + 10'h001;
                    end
                end
            end
        end
    endgenerate

    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            prv_ff <= 4'h0;
        end else begin
            prv_ff <= flt;
        end
    end

    // Edge evaluation
    logic a_edge, b_edge, a_rise, cnt_edge, up_raw, up;
    assign a_edge = flt[0] ^ prv_ff[0];
    assign b_edge = flt[1] ^ prv_ff[1];
    assign a_rise = a_edge & flt[0];
    always_comb begin
        cnt_edge = 1'b0;
        up_raw = 1'b0;
        case (eval_mode)
            CCC_EV_PULSE_DIR: begin
                cnt_edge = a_rise;
                up_raw = ~flt[1];
            end
            CCC_EV_ENC_X1: begin
                cnt_edge = a_rise;
                up_raw = ~flt[1];
            end
            CCC_EV_ENC_X2: begin
                cnt_edge = a_edge;
                up_raw = flt[0] ^ flt[1];
            end
            CCC_EV_ENC_X4: begin
                cnt_edge = a_edge | b_edge;
                up_raw = a_edge ? (flt[0] ^ flt[1]) : ~(flt[0] ^ flt[1]);
            end
            default: begin
                cnt_edge = 1'b0;
                up_raw = 1'b0;
            end
        endcase
    end
    assign up = up_raw ^ ctrl_ff[`CCC_C_DINV];

    // Gate
    logic sw_gate, hw_en, gate_open, gate_prv_ff, step;
    assign sw_gate = ctrl_ff[`CCC_C_SWGATE];
    assign hw_en = ctrl_ff[`CCC_C_HWEN];
    assign gate_open = sw_gate & (~hw_en | flt[2]);
    assign step = gate_open & cnt_edge;
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            gate_prv_ff <= 1'b0;
        end else begin
            gate_prv_ff <= gate_open;
        end
    end

    // Counter with wrap between the limits
    logic at_hi, at_lo;
    assign at_hi = (count_ff == hi_ff);
    assign at_lo = (count_ff == lo_ff);
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            count_ff <= 32'sh00000000;
        end else if (gate_open && !gate_prv_ff && !ctrl_ff[`CCC_C_STOP]) begin
            count_ff <= load_ff;
        end else if (step && up) begin
            count_ff <= at_hi ? lo_ff : count_ff + 32'sh00000001;
        end else if (step) begin
            count_ff <= at_lo ? hi_ff : count_ff - 32'sh00000001;
        end
    end

    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            latch_ff <= 32'sh00000000;
        end else if (flt[3] && !prv_ff[3]) begin
            latch_ff <= count_ff;
        end
    end

    // Comparator with hysteresis band
    logic [7:0] hyst;
    logic signed [32:0] cnt_x, band_lo, band_hi;
    logic flag_ff, armed_ff, reach, nxt_flag, cmp_hit;
    assign hyst = (cfg_ff[`CCC_G_HYST] > `CCC_HYST_MIN) ? cfg_ff[`CCC_G_HYST] : 8'h00;
    assign cnt_x = {count_ff[31], count_ff};
    assign band_lo = {cmp_ff[31], cmp_ff} - $signed({25'h0000000, hyst});
    assign band_hi = {cmp_ff[31], cmp_ff} + $signed({25'h0000000, hyst});
    assign reach = armed_ff && (count_ff == cmp_ff);

    logic [8:0] ms_left_ff;
    logic [9:0] ms_us_ff;
    always_comb begin
        case (omode)
            CCC_OM_GE: nxt_flag = flag_ff ? (cnt_x >= band_lo) : (count_ff >= cmp_ff);
            CCC_OM_LE: nxt_flag = flag_ff ? (cnt_x <= band_hi) : (count_ff <= cmp_ff);
            CCC_OM_PULSE: nxt_flag = (ms_left_ff != 9'h000);
            default: nxt_flag = 1'b0;
        endcase
    end
    assign cmp_hit = (omode == CCC_OM_PULSE) ? reach : (nxt_flag & ~flag_ff);

    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            flag_ff <= 1'b0;
        end else begin
            flag_ff <= nxt_flag;
        end
    end

    // Pulse mode re-arms only once the count leaves the band
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            armed_ff <= 1'b1;
        end else if (reach) begin
            armed_ff <= 1'b0;
        end else if (cnt_x < band_lo || cnt_x > band_hi) begin
            armed_ff <= 1'b1;
        end
    end

    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            ms_left_ff <= 9'h000;
            ms_us_ff <= 10'h000;
        end else if (reach && omode == CCC_OM_PULSE) begin
            ms_left_ff <= cfg_ff[`CCC_G_PULSE];
            ms_us_ff <= 10'h000;
        end else if (us_tick && ms_left_ff != 9'h000) begin
            if (ms_us_ff == 10'(`CCC_MS_US - 1)) begin
                ms_us_ff <= 10'h000;
                ms_left_ff <= ms_left_ff - 9'h001;
            end else begin
                ms_us_ff <= ms_us_ff + 10'h001;
            end
        end
    end
    assign cmp_out = flag_ff;

    // Period between counting edges, only at the lowest frequency
    logic base_tick;
    assign base_tick = ctrl_ff[`CCC_C_TB1US] ? us_tick : tb_tick;
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            per_cnt_ff <= 32'h00000000;
            period_ff <= 32'h00000000;
        end else if (!f1k) begin
            per_cnt_ff <= 32'h00000000;
            period_ff <= 32'h00000000;
        end else if (step) begin
            period_ff <= per_cnt_ff;
            per_cnt_ff <= 32'h00000000;
        end else if (base_tick && per_cnt_ff != 32'hffffffff) begin
            per_cnt_ff <= per_cnt_ff + 32'h00000001;
        end
    end

    // Interrupt events
    always_comb begin
        ev_set = '0;
        ev_set[`CCC_I_HWOPEN] = hw_en & sw_gate & flt[2] & ~prv_ff[2];
        ev_set[`CCC_I_HWCLOSE] = hw_en & sw_gate & ~flt[2] & prv_ff[2];
        ev_set[`CCC_I_CMP] = cmp_hit;
        ev_set[`CCC_I_OVF] = step & up & at_hi;
        ev_set[`CCC_I_UNF] = step & ~up & at_lo;
        ev_set[`CCC_I_EDGE] = step & f1k;
    end

    // APB slave: no wait states, data latched in the setup cycle
    assign acc = psel & penable;
    assign wr_acc = acc & pwrite;
    assign pready = 1'b1;
    assign pslverr = acc & err_ff;
    assign prdata = prdata_ff;
    assign ev_clr = (acc && !pwrite && paddr == `CCC_A_ISTAT) ? prdata_ff[`CCC_I_W-1:0] : '0;

    always_comb begin
        rd_data = 32'h00000000;
        rd_err = 1'b0;
        case (paddr)
            `CCC_A_CTRL: rd_data = {16'h0000, ctrl_ff};
            `CCC_A_CMP: rd_data = cmp_ff;
            `CCC_A_LOAD: rd_data = load_ff;
            `CCC_A_CFG: rd_data = {15'h0000, cfg_ff};
            `CCC_A_HI: rd_data = hi_ff;
            `CCC_A_LO: rd_data = lo_ff;
            `CCC_A_COUNT: rd_data = count_ff;
            `CCC_A_INDATA: rd_data = (f1k && ctrl_ff[`CCC_C_PERSEL]) ? period_ff : count_ff;
            `CCC_A_LATCH: rd_data = latch_ff;
            `CCC_A_ISTAT: rd_data = {26'h0000000, istat_ff};
            `CCC_A_IMASK: rd_data = {26'h0000000, imask_ff};
            `CCC_A_STATUS: rd_data = {29'h00000000, up, gate_open, flag_ff};
            default: rd_err = 1'b1;
        endcase
    end

    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            prdata_ff <= 32'h00000000;
            err_ff <= 1'b0;
        end else if (psel && !penable) begin
            prdata_ff <= pwrite ? 32'h00000000 : rd_data;
            err_ff <= rd_err;
        end
    end

    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            ctrl_ff <= `CCC_CTRL_RST;
            cfg_ff <= `CCC_CFG_RST;
            cmp_ff <= 32'sh00000000;
            load_ff <= 32'sh00000000;
            hi_ff <= `CCC_HI_RST;
            lo_ff <= `CCC_LO_RST;
            imask_ff <= '0;
        end else if (wr_acc) begin
            case (paddr)
                `CCC_A_CTRL: ctrl_ff <= pwdata[`CCC_CTRL_W-1:0];
                `CCC_A_CMP: cmp_ff <= pwdata;
                `CCC_A_LOAD: load_ff <= pwdata;
                // Odd pulse lengths are rounded down to the even value below
                `CCC_A_CFG: cfg_ff <= {pwdata[`CCC_CFG_W-1:`CCC_G_PULSE_LSB+1], 1'b0,
                                       pwdata[`CCC_G_PULSE_LSB-1:0]};
                `CCC_A_HI: hi_ff <= pwdata;
                `CCC_A_LO: lo_ff <= pwdata;
                `CCC_A_IMASK: imask_ff <= pwdata[`CCC_I_W-1:0];
                default: ;
            endcase
        end
    end

    // Set wins over a read clear in the same cycle
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            istat_ff <= '0;
            irq_ff <= 1'b0;
        end else begin
            istat_ff <= (istat_ff & ~ev_clr) | ev_set;
            irq_ff <= |(istat_ff & imask_ff);
        end
    end
    assign irq = irq_ff;

endmodule : ccc_counter
`default_nettype wire

// ---- ccc_counter_chk.sv ----
// Port-level assertions of the counter channel and their bind
`timescale 1ns/100ps
`default_nettype none
`include "ccc_map.svh"
module ccc_counter_chk (
    input wire logic clock,
    input wire logic rst_n,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic pready,
    input wire logic [31:0] prdata,
    input wire logic pslverr,
    input wire logic cmp_out,
    input wire logic irq
);
    default clocking @(posedge clock);
    endclocking
    default disable iff (!rst_n);
    logic acc;
    logic clr;
    logic [5:0] mask_ff;
    logic [1:0] mz_ff;
    assign acc = psel && penable;
    assign clr = acc && (pwrite ? paddr == `CCC_A_IMASK : paddr == `CCC_A_ISTAT);
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            mask_ff <= 6'h00;
        end else if (acc && pwrite && paddr == `CCC_A_IMASK) begin
            mask_ff <= pwdata[5:0];
        end
    end
    // Cycles the mask has stayed clear, so the irq register lag is allowed for
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            mz_ff <= 2'h3;
        end else if (mask_ff != 6'h00) begin
            mz_ff <= 2'h0;
        end else if (mz_ff != 2'h3) begin
            mz_ff <= mz_ff + 2'h1;
        end
    end
    ready_now_a: assert property (acc |-> pready)
        else $error("ready low in access");
    bad_addr_a: assert property (acc && paddr > `CCC_A_STATUS |-> pslverr && prdata == 32'h0)
        else $error("unmapped access not refused");
    good_addr_a: assert property (acc && paddr[1:0] == 2'h0 && paddr <= `CCC_A_STATUS |-> !pslverr)
        else $error("mapped access refused");
    err_phase_a: assert property (pslverr |-> acc)
        else $error("error outside access");
    rdata_hold_a: assert property (acc |=> $stable(prdata))
        else $error("read data moved");
    reset_quiet_a: assert property ($rose(rst_n) |-> !irq && !cmp_out && prdata == 32'h0)
        else $error("outputs busy after reset");
    mask_echo_a:
        assert property (acc && !pwrite && paddr == `CCC_A_IMASK |-> prdata == {26'h0, mask_ff})
        else $error("mask read back wrong");
    irq_masked_a: assert property (mz_ff == 2'h3 |-> !irq)
        else $error("irq with all sources masked");
    irq_rise_a: assert property ($rose(irq) |-> $past(mask_ff) != 6'h00)
        else $error("irq rose while masked");
    irq_fall_a: assert property ($fell(irq) |-> $past(clr) || $past(clr, 2) || $past(clr, 3))
        else $error("irq fell without clear");
    irq_seen_c: cover property ($rose(irq));
    cmp_seen_c: cover property ($rose(cmp_out));
    refused_c: cover property (acc && pslverr);
endmodule : ccc_counter_chk
bind ccc_counter ccc_counter_chk ccc_counter_chk_i (.clock(clock), .rst_n(rst_n), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready),
    .prdata(prdata), .pslverr(pslverr), .cmp_out(cmp_out), .irq(irq));
`default_nettype wire

// ---- ccc_enc_model.sv ----
// Pulse/direction and quadrature encoder source for the track inputs
`timescale 1ns/100ps
`default_nettype none
module ccc_enc_model (
    input wire logic clock,
    output var logic trk_a,
    output var logic trk_b
);
    // Every level outlasts the 60 kHz filter plus one tick of phase
    localparam int HALF = 1000;
    initial begin
        trk_a = 1'b0;
        trk_b = 1'b0;
    end
    task automatic pulses(input int n, input logic dn);
        trk_b <= dn;
        repeat (n) begin
            repeat (HALF) @(posedge clock);
            trk_a <= 1'b1;
            repeat (HALF) @(posedge clock);
            trk_a <= 1'b0;
        end
        repeat (HALF) @(posedge clock);
    endtask : pulses
    // Forward is A leading B; one track moves per step
    task automatic quad(input int n, input logic up);
        repeat (n) begin
            repeat (HALF) @(posedge clock);
            if ((trk_a == trk_b) == up) begin
                trk_a <= ~trk_a;
            end else begin
                trk_b <= ~trk_b;
            end
        end
        repeat (HALF) @(posedge clock);
    endtask : quad
endmodule : ccc_enc_model
`default_nettype wire

// ---- ccc_map.svh ----
// Register offsets, field positions, reset values and timing of the counter channel
`ifndef CCC_MAP_SVH
`define CCC_MAP_SVH

`define CCC_A_CTRL 12'h000
`define CCC_A_CMP 12'h004
`define CCC_A_LOAD 12'h008
`define CCC_A_CFG 12'h00c
`define CCC_A_HI 12'h010
`define CCC_A_LO 12'h014
`define CCC_A_COUNT 12'h018
`define CCC_A_INDATA 12'h01c
`define CCC_A_LATCH 12'h020
`define CCC_A_ISTAT 12'h024
`define CCC_A_IMASK 12'h028
`define CCC_A_STATUS 12'h02c

`define CCC_C_SWGATE 0
`define CCC_C_HWEN 1
`define CCC_C_DINV 2
`define CCC_C_STOP 3
`define CCC_C_EVAL 5:4
`define CCC_C_OMODE 7:6
`define CCC_C_PERSEL 8
`define CCC_C_TB1US 9
`define CCC_C_CFREQ 12:10
`define CCC_C_LFREQ 15:13
`define CCC_CTRL_W 16
`define CCC_CTRL_RST 16'h6c00

`define CCC_G_HYST 7:0
`define CCC_G_PULSE 16:8
`define CCC_G_PULSE_LSB 8
`define CCC_CFG_W 17
`define CCC_CFG_RST 17'h00000

`define CCC_I_HWOPEN 0
`define CCC_I_HWCLOSE 1
`define CCC_I_CMP 2
`define CCC_I_OVF 3
`define CCC_I_UNF 4
`define CCC_I_EDGE 5
`define CCC_I_W 6

`define CCC_S_CMPFLAG 0
`define CCC_S_GATE 1
`define CCC_S_UP 2

`define CCC_HI_RST 32'h7fffffff
`define CCC_LO_RST 32'h80000000

`define CCC_CLK_NS 10
`define CCC_US_NS 1000
`define CCC_US_CYC (`CCC_US_NS / `CCC_CLK_NS)
`define CCC_TB_NS 125
`define CCC_TB_HALF_CYC (`CCC_TB_NS / `CCC_CLK_NS)
`define CCC_TB_PAIR_CYC ((2 * `CCC_TB_NS) / `CCC_CLK_NS)
`define CCC_MS_US 1000
`define CCC_HYST_MIN 8'h01

`define CCC_FLT_1K_US 10'h1f4
`define CCC_FLT_2K_US 10'h0fa
`define CCC_FLT_5K_US 10'h064
`define CCC_FLT_10K_US 10'h032
`define CCC_FLT_30K_US 10'h010
`define CCC_FLT_60K_US 10'h008

`endif

// ---- ccc_pkg.sv ----
// Mode and option types of the counter channel
package ccc_pkg;
    typedef enum logic [1:0] {CCC_EV_PULSE_DIR, CCC_EV_ENC_X1, CCC_EV_ENC_X2, CCC_EV_ENC_X4}
        ccc_eval_t;
    typedef enum logic [1:0] {CCC_OM_NONE, CCC_OM_GE, CCC_OM_LE, CCC_OM_PULSE} ccc_omode_t;
    typedef enum logic [2:0] {CCC_F_1K, CCC_F_2K, CCC_F_5K, CCC_F_10K, CCC_F_30K, CCC_F_60K}
        ccc_freq_t;
endpackage : ccc_pkg

// ---- continuous_counter_config_tb_top.sv ----
// Self-checking bench of the counter channel with an encoder source
`timescale 1ns/100ps
`default_nettype none
`include "ccc_map.svh"
module continuous_counter_config_tb_top;
    logic clock = 1'b0;
    logic rst_n = 1'b0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0;
    logic hw_gate = 1'b0;
    logic latch_in = 1'b0;
    logic pready, pslverr, cmp_out, irq, trk_a, trk_b, err_q;
    logic [31:0] prdata, rd_q, lf, ld, cv, ex;
    int failures = 0;
    int n_compared = 0;
    int n;
    always #5 clock = ~clock;
    ccc_counter ccc_counter_i (.clock(clock), .rst_n(rst_n), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready), .prdata(prdata),
        .pslverr(pslverr), .trk_a(trk_a), .trk_b(trk_b), .hw_gate(hw_gate),
        .latch_in(latch_in), .cmp_out(cmp_out), .irq(irq));
    ccc_enc_model ccc_enc_model_i (.clock(clock), .trk_a(trk_a), .trk_b(trk_b));
    function automatic logic [31:0] lfsr(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction : lfsr
    // Default limits coincide with two's-complement wrap
    function automatic logic [31:0] step(input logic [31:0] v, input int k);
        return v + 32'(k);
    endfunction : step
    task automatic wrap_up;
        $display("compared %0d failures %0d", n_compared, failures);
        if (failures == 0 && n_compared > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask : wrap_up
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_compared++;
        if (got !== exp) begin
            failures++;
            $display("unexpected at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk
    task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
        int k;
        @(posedge clock);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge clock);
        penable <= 1'b1;
        k = 0;
        do begin
            @(posedge clock);
            k++;
        end while (pready !== 1'b1 && k < 20);
        rd_q = prdata;
        err_q = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        if (k >= 20) begin
            failures++;
            wrap_up();
        end
    endtask : apb
    // Pins are looked at mid-cycle, clear of the edge that launches them
    task automatic pin(input logic sel_irq, input logic exp);
        @(negedge clock);
        chk({31'h0, sel_irq ? irq : cmp_out}, {31'h0, exp});
        @(posedge clock);
    endtask : pin
    task automatic rd(input logic [11:0] a, input logic [31:0] exp);
        apb(1'b0, a, 32'h0);
        chk(rd_q, exp);
    endtask : rd
    initial begin
        lf = 32'h00000032;
        repeat (10) @(posedge clock);
        rst_n <= 1'b1;
        rd(`CCC_A_CTRL, 32'h00006c00);
        rd(`CCC_A_HI, `CCC_HI_RST);
        rd(`CCC_A_LO, `CCC_LO_RST);
        rd(`CCC_A_IMASK, 32'h0);
        apb(1'b1, `CCC_A_COUNT, 32'h1);
        rd(`CCC_A_COUNT, 32'h0);
        apb(1'b0, 12'h030, 32'h0);
        chk({31'h0, err_q}, 32'h1);
        apb(1'b1, `CCC_A_CFG, 32'h00000301);
        rd(`CCC_A_CFG, 32'h00000201);
        $display("test reset done");
        lf = lfsr(lf);
        ld = {8'h00, lf[23:0]};
        n = int'(lf[24]) + 1;
        apb(1'b1, `CCC_A_LOAD, ld);
        apb(1'b1, `CCC_A_IMASK, 32'h0000003f);
        apb(1'b1, `CCC_A_CTRL, 32'h00007501);
        ccc_enc_model_i.pulses(n, 1'b0);
        ex = step(ld, n);
        rd(`CCC_A_COUNT, ex);
        rd(`CCC_A_INDATA, ex);
        ccc_enc_model_i.pulses(n, 1'b1);
        rd(`CCC_A_COUNT, ld);
        apb(1'b1, `CCC_A_CTRL, 32'h00007505);
        ccc_enc_model_i.pulses(n, 1'b1);
        rd(`CCC_A_COUNT, ex);
        $display("test counting done");
        apb(1'b0, `CCC_A_ISTAT, 32'h0);
        apb(1'b1, `CCC_A_CTRL, 32'h00007503);
        ccc_enc_model_i.pulses(1, 1'b0);
        rd(`CCC_A_COUNT, ex);
        hw_gate <= 1'b1;
        repeat (1000) @(posedge clock);
        pin(1'b1, 1'b1);
        rd(`CCC_A_COUNT, ld);
        rd(`CCC_A_ISTAT, 32'h1);
        hw_gate <= 1'b0;
        repeat (1000) @(posedge clock);
        rd(`CCC_A_ISTAT, 32'h2);
        // Stop mode must keep the count although the load value differs
        apb(1'b1, `CCC_A_LOAD, 32'h0);
        apb(1'b1, `CCC_A_CTRL, 32'h00007509);
        rd(`CCC_A_COUNT, ld);
        $display("test gate done");
        apb(1'b1, `CCC_A_CTRL, 32'h00007500);
        apb(1'b1, `CCC_A_LOAD, `CCC_HI_RST);
        apb(1'b1, `CCC_A_CTRL, 32'h00007501);
        ccc_enc_model_i.pulses(1, 1'b0);
        rd(`CCC_A_COUNT, `CCC_LO_RST);
        rd(`CCC_A_ISTAT, 32'h8);
        ccc_enc_model_i.pulses(1, 1'b1);
        rd(`CCC_A_COUNT, `CCC_HI_RST);
        rd(`CCC_A_ISTAT, 32'h10);
        // A 10 us pulse passes the count filter but not the 10 kHz latch filter
        latch_in <= 1'b1;
        repeat (1000) @(posedge clock);
        latch_in <= 1'b0;
        repeat (1000) @(posedge clock);
        rd(`CCC_A_LATCH, 32'h0);
        latch_in <= 1'b1;
        repeat (6000) @(posedge clock);
        rd(`CCC_A_LATCH, `CCC_HI_RST);
        latch_in <= 1'b0;
        $display("test limits done");
        lf = lfsr(lf);
        cv = {8'h00, lf[23:0]};
        apb(1'b1, `CCC_A_CMP, cv);
        apb(1'b1, `CCC_A_LOAD, step(cv, -2));
        apb(1'b1, `CCC_A_CTRL, 32'h00007500);
        apb(1'b1, `CCC_A_CTRL, 32'h00007541);
        ccc_enc_model_i.pulses(1, 1'b0);
        pin(1'b0, 1'b0);
        ccc_enc_model_i.pulses(1, 1'b0);
        pin(1'b0, 1'b1);
        rd(`CCC_A_ISTAT, 32'h4);
        apb(1'b1, `CCC_A_CTRL, 32'h00007581);
        ccc_enc_model_i.pulses(1, 1'b0);
        pin(1'b0, 1'b0);
        ccc_enc_model_i.pulses(1, 1'b1);
        rd(`CCC_A_ISTAT, 32'h4);
        // Band of two keeps the flag one step below the compare value
        apb(1'b1, `CCC_A_CFG, 32'h00000002);
        apb(1'b1, `CCC_A_CTRL, 32'h00007541);
        ccc_enc_model_i.pulses(1, 1'b1);
        pin(1'b0, 1'b1);
        $display("test compare done");
        ex = step(cv, -1);
        for (int m = 1; m < 4; m++) begin
            apb(1'b1, `CCC_A_CTRL, 32'h00007501 | (32'(m) << 4));
            ccc_enc_model_i.quad(8, 1'b1);
            ex = step(ex, 2 << (m - 1));
            rd(`CCC_A_COUNT, ex);
        end
        ccc_enc_model_i.quad(4, 1'b0);
        rd(`CCC_A_COUNT, step(ex, -4));
        $display("test encoder done");
        wrap_up();
    end
endmodule : continuous_counter_config_tb_top
`default_nettype wire
